/* line_status_interrupt_regs.v */
`timescale 1ns/10ps
`default_nettype none
`include "line_status_regs.vh"

module line_status_interrupt_regs (
    // APB slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Real-time line conditions
    input  wire        far_loopback_active,
    input  wire [5:0]  line_attenuation_raw,
    input  wire        equalizer_out_of_range,
    input  wire        inband_activate_seen,
    input  wire        inband_deactivate_seen,
    input  wire        pattern_sync,
    input  wire        driver_fault,
    input  wire        alarm_indication,
    input  wire        signal_absent,
    input  wire        tx_line_clock_input,
    // Pulse events for status B
    input  wire        waveform_amplitude_overflow_event,
    input  wire        jitter_buffer_overflow_event,
    input  wire        jitter_buffer_underflow_event,
    input  wire        pattern_bit_error_event,
    input  wire        excess_zeros_event,
    input  wire        code_violation_event,
    input  wire        second_timer_expiry_event,
    input  wire        error_counter_overflow_event,
    // Interrupt requests and transmit clock loss flag
    output reg         irq_status_a,
    output reg         irq_status_b,
    output reg         tx_clock_missing
);

    // ****************************************
    // State
    // ****************************************
    reg  [7:0]                   status_a_reg;
    reg  [7:0]                   status_b_reg;
    reg  [7:0]                   mask_reg;
    reg  [7:0]                   edge_sel_reg;
    reg  [7:0]                   realtime_prev_reg;
    reg  [`TX_CLOCK_CNT_W-1:0]   tx_idle_cnt_reg;
    reg                          tx_clk_prev_reg;
    reg                          tx_lost_reg;
    reg  [7:0]                   status_a_next;
    reg  [7:0]                   status_b_next;
    reg  [`TX_CLOCK_CNT_W-1:0]   tx_idle_cnt_next;
    reg  [31:0]                  rdata_next;
    reg                          err_next;

    wire        setup_phase;
    wire        access_rd;
    wire        access_wr;
    wire [7:0]  realtime_now;
    wire [7:0]  event_a;
    wire [7:0]  event_b;
    wire [4:0]  atten_code;
    wire [7:0]  line_status;
    wire        read_a;
    wire        read_b;

    // ****************************************
    // Bus decode
    // ****************************************
    // Zero wait states: answer in the first access cycle
    assign setup_phase = psel & ~penable;
    assign access_rd   = psel & penable & ~pwrite;
    assign access_wr   = psel & penable & pwrite;
    assign read_a      = access_rd & (paddr == `ADDR_EVENT_STATUS_A);
    assign read_b      = access_rd & (paddr == `ADDR_EVENT_STATUS_B);

    // ****************************************
    // Line status composition
    // ****************************************
    // Saturate raw measurement, beyond the top step all codes mean over 44 dB
    assign atten_code  = (line_attenuation_raw > {1'b0, `ATTEN_MAX_CODE}) ? `ATTEN_MAX_CODE :
                         line_attenuation_raw[`ATTEN_MSB:0];
    assign line_status = {2'b00, far_loopback_active, atten_code};

    // ****************************************
    // Transmit clock watchdog
    // ****************************************
    always @* begin
        if (tx_line_clock_input != tx_clk_prev_reg) begin
            tx_idle_cnt_next = {`TX_CLOCK_CNT_W{1'b0}};
        end else if (tx_idle_cnt_reg != `TX_CLOCK_LOSS_CYCLES) begin
            tx_idle_cnt_next = tx_idle_cnt_reg + 1'b1;
        end else begin
            tx_idle_cnt_next = tx_idle_cnt_reg;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_clk_prev_reg  <= 1'b0;
            tx_idle_cnt_reg  <= {`TX_CLOCK_CNT_W{1'b0}};
            tx_lost_reg      <= 1'b0;
            tx_clock_missing <= 1'b0;
        end else begin
            tx_clk_prev_reg  <= tx_line_clock_input;
            tx_idle_cnt_reg  <= tx_idle_cnt_next;
            // Set once idle count reaches 70 cycles
            tx_lost_reg      <= (tx_idle_cnt_next == `TX_CLOCK_LOSS_CYCLES);
            tx_clock_missing <= (tx_idle_cnt_next == `TX_CLOCK_LOSS_CYCLES);
        end
    end

    // ****************************************
    // Event detection
    // ****************************************
    assign realtime_now = {equalizer_out_of_range,
                           inband_activate_seen,
                           inband_deactivate_seen,
                           pattern_sync,
                           tx_lost_reg,
                           driver_fault,
                           alarm_indication,
                           signal_absent};

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_evt
            // Mask 1 blocks; edge-select 1 counts either direction
            assign event_a[i] = ~mask_reg[i] &
                                (edge_sel_reg[i] ? (realtime_now[i] ^ realtime_prev_reg[i])
                                                 : (realtime_now[i] & ~realtime_prev_reg[i]));
        end
    endgenerate

    assign event_b = {waveform_amplitude_overflow_event,
                      jitter_buffer_overflow_event,
                      jitter_buffer_underflow_event,
                      pattern_bit_error_event,
                      excess_zeros_event,
                      code_violation_event,
                      second_timer_expiry_event,
                      error_counter_overflow_event};

    // ****************************************
    // Sticky status
    // ****************************************
    // Set beats clear so an event during the read is not lost
    always @* begin
        status_a_next = (read_a ? 8'h00 : status_a_reg) | event_a;
        status_b_next = (read_b ? 8'h00 : status_b_reg) | event_b;
    end

    // ****************************************
    // Read mux
    // ****************************************
    always @* begin
        rdata_next = 32'h0000_0000;
        err_next   = 1'b0;
        // Report what the access edge clears, so an event landing at setup is not lost
        case (paddr)
            `ADDR_LINE_STATUS:     rdata_next = {24'h000000, line_status};
            `ADDR_EVENT_STATUS_A:  rdata_next = {24'h000000, status_a_next};
            `ADDR_EVENT_STATUS_B:  rdata_next = {24'h000000, status_b_next};
            `ADDR_EVENT_MASK:      rdata_next = {24'h000000, mask_reg};
            `ADDR_EDGE_SELECT:     rdata_next = {24'h000000, edge_sel_reg};
            `ADDR_REALTIME_STATUS: rdata_next = {24'h000000, realtime_now};
            default:               err_next   = 1'b1;
        endcase
        // Status and line registers are read-only
        if (pwrite && (paddr != `ADDR_EVENT_MASK) && (paddr != `ADDR_EDGE_SELECT)) begin
            err_next = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_a_reg      <= `RESET_STATUS;
            status_b_reg      <= `RESET_STATUS;
            mask_reg          <= `RESET_MASK;
            edge_sel_reg      <= `RESET_EDGE;
            realtime_prev_reg <= 8'h00;
            irq_status_a      <= 1'b0;
            irq_status_b      <= 1'b0;
            prdata            <= 32'h0000_0000;
            pready            <= 1'b0;
            pslverr           <= 1'b0;
        end else begin
            realtime_prev_reg <= realtime_now;
            status_a_reg      <= status_a_next;
            status_b_reg      <= status_b_next;
            irq_status_a      <= |status_a_next;
            // Request drops with the clearing read
            irq_status_b      <= |status_b_next;
            if (access_wr && paddr == `ADDR_EVENT_MASK) begin
                mask_reg <= pwdata[7:0];
            end
            if (access_wr && paddr == `ADDR_EDGE_SELECT) begin
                edge_sel_reg <= pwdata[7:0];
            end
            // Answer prepared in setup so pready stands in the access cycle
            pready  <= setup_phase;
            pslverr <= setup_phase & err_next;
            if (setup_phase && !pwrite) begin
                prdata <= rdata_next;
            end
        end
    end

endmodule
`default_nettype wire

/* line_status_interrupt_regs_sva.sv */
`timescale 1ns/10ps
`default_nettype none
`include "line_status_regs.vh"
module line_status_interrupt_regs_sva (
    // Bus
    input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    // Line side
    input wire logic        irq_status_a, irq_status_b, tx_clock_missing, tx_line_clock_input,
    input wire logic        waveform_amplitude_overflow_event, jitter_buffer_overflow_event,
    input wire logic        jitter_buffer_underflow_event, pattern_bit_error_event, excess_zeros_event,
    input wire logic        code_violation_event, second_timer_expiry_event, error_counter_overflow_event
);
    wire logic  rd_ok = psel && penable && pready && !pwrite && !pslverr;
    wire logic  rd_a  = rd_ok && paddr == `ADDR_EVENT_STATUS_A;
    wire logic  rd_b  = rd_ok && paddr == `ADDR_EVENT_STATUS_B;
    wire logic  b_any = waveform_amplitude_overflow_event | jitter_buffer_overflow_event |
                        jitter_buffer_underflow_event | pattern_bit_error_event | excess_zeros_event |
                        code_violation_event | second_timer_expiry_event | error_counter_overflow_event;
    logic       tx_prev;
    logic [6:0] still_cnt;
    // ****************************************
    // Quiet time of the transmit clock
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_prev   <= 1'b0;
            still_cnt <= 7'h00;
        end else begin
            tx_prev   <= tx_line_clock_input;
            still_cnt <= (tx_line_clock_input != tx_prev) ? 7'h00 : still_cnt + {6'h00, still_cnt != 7'h7F};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wave_irq_a: assert property (waveform_amplitude_overflow_event |-> ##[1:2] irq_status_b)
        else $error("no request after waveform event");
    cnt_irq_a: assert property (error_counter_overflow_event |-> ##[1:2] irq_status_b)
        else $error("no request after counter event");
    b_clear_a: assert property (rd_b && !b_any |=> !irq_status_b)
        else $error("status b request kept after read");
    b_hold_a: assert property (irq_status_b && !rd_b && !$past(rd_b) |=> irq_status_b)
        else $error("status b dropped without read");
    a_hold_a: assert property (irq_status_a && !rd_a && !$past(rd_a) |=> irq_status_a)
        else $error("status a dropped without read");
    tx_quiet_a: assert property (still_cnt >= 7'h03 && still_cnt <= 7'h45 |-> !tx_clock_missing)
        else $error("clock loss flagged too early");
    tx_lost_a: assert property (still_cnt >= 7'h46 |-> tx_clock_missing)
        else $error("clock loss not flagged");
    line_rsvd_a: assert property (rd_ok && paddr == `ADDR_LINE_STATUS |-> prdata[31:6] == 26'h0)
        else $error("line status high bits set");
endmodule
bind line_status_interrupt_regs line_status_interrupt_regs_sva u_sva (.*);
`default_nettype wire

/* line_status_regs.vh */
// Functional notes
// - Bit 5 of line status reads 1 while far loopback is closed, else 0.
// - Bits 4..0 report attenuation code; codes 10110 and above mean over 44 dB.
// - Reading status A clears all its bits.
// - Reading status B clears it and withdraws the request it raised.
// - Status A bit 7 latches equalizer out-of-range events.
// - Status A bit 6 latches inband activate-code events.
// - Status A bit 5 latches inband deactivate-code events.
// - Status A bit 4 latches pattern sync status events.
// - Status A bit 3 latches transmit clock loss events.
// - Status A bit 2 latches line driver fault events.
// - Status A bit 1 latches alarm indication events.
// - Status A bit 0 latches loss-of-signal events.
// - Status B bit 7 latches waveform amplitude overflow.
// - Status B bit 6 latches jitter buffer overflow.
// - Status B bit 5 latches jitter buffer underflow.
// - Status B bit 4 latches pattern bit error events.
// - Status B bit 3 latches excessive zeros events.
// - Status B bit 2 latches code violation events.
// - Status B bit 1 latches one-second timer expiry.
// - Status B bit 0 latches error counter overflow.
// - Unmasked real-time bits raise events on rise, or any change if edge-select set.
// - Transmit clock is lost when untoggled for more than 70 clock cycles.
`ifndef LINE_STATUS_REGS_VH
`define LINE_STATUS_REGS_VH

// Byte addresses are four times these indices
`define IDX_LINE_STATUS      8'h15
`define IDX_EVENT_STATUS_A   8'h16
`define IDX_EVENT_STATUS_B   8'h17
`define IDX_EVENT_MASK       8'h20
`define IDX_EDGE_SELECT      8'h21
`define IDX_REALTIME_STATUS  8'h22

`define ADDR_LINE_STATUS     12'h054
`define ADDR_EVENT_STATUS_A  12'h058
`define ADDR_EVENT_STATUS_B  12'h05C
`define ADDR_EVENT_MASK      12'h080
`define ADDR_EDGE_SELECT     12'h084
`define ADDR_REALTIME_STATUS 12'h088

`define BIT_FAR_LOOPBACK     5
`define ATTEN_MSB            4
`define ATTEN_SATURATE       5'h16
`define ATTEN_MAX_CODE       5'h1F

`define RESET_STATUS         8'h00
`define RESET_MASK           8'hFF
`define RESET_EDGE           8'h00

`define TX_CLOCK_LOSS_CYCLES 7'h46
`define TX_CLOCK_CNT_W       7

`endif

/* tb_line_status_interrupt_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "line_status_regs.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module tb_line_status_interrupt_regs;
    logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        far_loopback_active = 1'b0, tx_line_clock_input = 1'b0, tx_run = 1'b1;
    logic        pready, pslverr, irq_status_a, irq_status_b, tx_clock_missing;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [7:0]  rt_a = 8'h00, ev_b = 8'h00;
    logic [5:0]  line_attenuation_raw = 6'h00;
    logic [33:0] exp_q[$], e;
    int          num_errors = 0, checks_done = 0;
    line_status_interrupt_regs u_dut (.*, .equalizer_out_of_range(rt_a[7]), .inband_activate_seen(rt_a[6]),
        .inband_deactivate_seen(rt_a[5]), .pattern_sync(rt_a[4]), .driver_fault(rt_a[2]),
        .alarm_indication(rt_a[1]), .signal_absent(rt_a[0]), .waveform_amplitude_overflow_event(ev_b[7]),
        .jitter_buffer_overflow_event(ev_b[6]), .jitter_buffer_underflow_event(ev_b[5]),
        .pattern_bit_error_event(ev_b[4]), .excess_zeros_event(ev_b[3]), .code_violation_event(ev_b[2]),
        .second_timer_expiry_event(ev_b[1]), .error_counter_overflow_event(ev_b[0]));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) if (tx_run) tx_line_clock_input <= ~tx_line_clock_input;
    // ****************************************
    // Bus transfers, expectation = {check data, error, data}
    // ****************************************
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [33:0] x,
                       input logic [7:0] ev);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
        exp_q.push_back(x);
        @(posedge pclk);
        penable <= 1'b1;
        ev_b <= ev;
        // No local limit: only the watchdog ends a wait
        do begin @(posedge pclk); ev_b <= 8'h00; end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [7:0] ev = 8'h00);
        apb(1'b0, a, 32'h0, {2'b10, 24'h0, d}, ev);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic final_report();
        $display("checks_done %0d num_errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            `CHK("expectation queue", 1'b1, exp_q.size() > 0)
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h0;
            `CHK("pslverr", e[32], pslverr)
            if (e[33]) `CHK("prdata", e[31:0], prdata)
        end
    end
    initial begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        final_report();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        void'($urandom(17132));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`ADDR_LINE_STATUS, 8'h00); rd(`ADDR_EVENT_STATUS_A, 8'h00); rd(`ADDR_EVENT_STATUS_B, 8'h00);
        rd(`ADDR_EVENT_MASK, 8'hFF); rd(`ADDR_EDGE_SELECT, 8'h00);
        rt_a <= 8'h01; idle(4); rt_a <= 8'h00; rd(`ADDR_EVENT_STATUS_A, 8'h00);
        apb(1'b1, `ADDR_EVENT_STATUS_A, 32'hFF, {2'b01, 32'h0}, 8'h00);
        apb(1'b0, 12'h0FC, 32'h0, {2'b01, 32'h0}, 8'h00);
        apb(1'b1, `ADDR_EVENT_MASK, 32'h0, 34'h0, 8'h00);
        for (int i = 0; i < 8; i++) begin
            ev_b <= 8'h01 << i; @(posedge pclk); ev_b <= 8'h00;
            rd(`ADDR_EVENT_STATUS_B, 8'h01 << i); rd(`ADDR_EVENT_STATUS_B, 8'h00);
        end
        rd(`ADDR_EVENT_STATUS_B, 8'h00, 8'h01); rd(`ADDR_EVENT_STATUS_B, 8'h01);
        for (int i = 0; i < 8; i++) if (i != 3) begin
            rt_a <= 8'h01 << i; idle(4); rt_a <= 8'h00; idle(4);
            rd(`ADDR_EVENT_STATUS_A, 8'h01 << i); rd(`ADDR_EVENT_STATUS_A, 8'h00);
        end
        tx_run <= 1'b0; idle(80); `CHK("tx_clock_missing", 1'b1, tx_clock_missing)
        rd(`ADDR_EVENT_STATUS_A, 8'h08);
        tx_run <= 1'b1; idle(6); `CHK("tx_clock_missing", 1'b0, tx_clock_missing)
        rd(`ADDR_EVENT_STATUS_A, 8'h00);
        apb(1'b1, `ADDR_EDGE_SELECT, 32'hFF, 34'h0, 8'h00);
        rt_a <= 8'hF7; idle(4); `CHK("irq_status_a", 1'b1, irq_status_a)
        rd(`ADDR_EVENT_STATUS_A, 8'hF7);
        rt_a <= 8'h00; idle(4); rd(`ADDR_EVENT_STATUS_A, 8'hF7); rd(`ADDR_EVENT_STATUS_A, 8'h00);
        for (int i = 0; i < 6; i++) begin
            line_attenuation_raw <= (i == 0) ? 6'h3F : (i == 1) ? 6'h16 : 6'($urandom);
            far_loopback_active <= (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($urandom);
            idle(3);
            rd(`ADDR_LINE_STATUS, {2'b00, far_loopback_active,
               (line_attenuation_raw > 6'h1F) ? 5'h1F : line_attenuation_raw[4:0]});
        end
        idle(2);
        `CHK("irq_status_a", 1'b0, irq_status_a)
        `CHK("irq_status_b", 1'b0, irq_status_b)
        final_report();
    end
endmodule
`default_nettype wire
